//--- smt_pkg.sv
package smt_pkg;
    // test request pin pair encodings (a,b)
    localparam logic [1:0] REQ_ADDR = 2'h3;
    localparam logic [1:0] REQ_WRITE = 2'h2;
    localparam logic [1:0] REQ_READ = 2'h1;
    localparam logic [1:0] REQ_EXIT = 2'h0;
    // control vector field positions
    localparam int CV_VALID = 0;
    localparam int CV_SIZE0 = 2;
    localparam int CV_SIZE1 = 3;
    localparam int CV_LOCK = 4;
    localparam int CV_PROT0 = 5;
    localparam int CV_PROT1 = 6;
    localparam int CV_INCR = 7;
    localparam int CV_PROT2 = 9;
    // reset values of the control settings
    localparam logic [2:0] SIZE_RST = 3'h2;
    localparam logic [3:0] PROT_RST = 4'h3;
    // bank decode
    localparam int BANK_LSB = 26;
    localparam logic [2:0] BANK_CODE_BOOT = 3'h0;
    localparam logic [2:0] BANK_BOOT = 3'h7;
    localparam int INCR_BITS = 8;
    // ahb transfer types
    localparam logic [1:0] TRANS_IDLE = 2'h0;
    localparam logic [1:0] TRANS_NSEQ = 2'h2;
endpackage

//--- smt_bank_if.sv
`timescale 1ns/1ps
`default_nettype none
interface smt_bank_if;
    logic [2:0] code;
    logic remap;
    logic sel;
    logic high;
    logic [7:0] cs;
    modport host (output code, output remap, output sel, output high, input cs);
    modport dec (input code, input remap, input sel, input high, output cs);
endinterface
`default_nettype wire

//--- smt_bank_dec.sv
`timescale 1ns/1ps
`default_nettype none
module smt_bank_dec (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    smt_bank_if.dec bus
);
    typedef struct packed {
        logic [7:0] cs;
    } smt_dec_st_t;
    smt_dec_st_t s_q;
    smt_dec_st_t s_d;
    logic [2:0] bank;

    // one-hot decode, reset map moves code zero to the top bank
    always_comb begin
        s_d = s_q;
        bank = bus.code;
        if (!bus.remap && bus.code == smt_pkg::BANK_CODE_BOOT) begin
            bank = smt_pkg::BANK_BOOT;
        end
        s_d.cs = bus.sel ? (8'h01 << bank) : 8'h00;
        if (!bus.high) begin
            s_d.cs = ~s_d.cs;
        end
    end

    // registered so the pads see no decode glitches; idle is all inactive low-active
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            s_q <= '{cs: 8'hFF};
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.cs = s_q.cs;
endmodule
`default_nettype wire

//--- smt_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface smt_ctl_if;
    logic load;
    logic [9:0] vec;
    logic [2:0] size;
    logic [3:0] prot;
    logic lock;
    logic incr;
    modport host (output load, output vec, input size, input prot, input lock, input incr);
    modport regs (input load, input vec, output size, output prot, output lock, output incr);
endinterface
`default_nettype wire

//--- smt_ctl_regs.sv
`timescale 1ns/1ps
`default_nettype none
module smt_ctl_regs (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    smt_ctl_if.regs ctl
);
    typedef struct packed {
        logic [2:0] size;
        logic [3:0] prot;
        logic lock;
        logic incr;
    } smt_ctl_st_t;
    smt_ctl_st_t s_q;
    smt_ctl_st_t s_d;

    // a control vector with its valid bit low leaves settings alone
    always_comb begin
        s_d = s_q;
        if (ctl.load && ctl.vec[smt_pkg::CV_VALID]) begin
            s_d.size = {1'b0, ctl.vec[smt_pkg::CV_SIZE1], ctl.vec[smt_pkg::CV_SIZE0]};
            s_d.lock = ctl.vec[smt_pkg::CV_LOCK];
            s_d.prot = {s_q.prot[3], ctl.vec[smt_pkg::CV_PROT2],
                        ctl.vec[smt_pkg::CV_PROT1], ctl.vec[smt_pkg::CV_PROT0]};
            s_d.incr = ctl.vec[smt_pkg::CV_INCR];
        end
    end

    // word, privileged data, no increment after reset
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            s_q <= '{size: smt_pkg::SIZE_RST, prot: smt_pkg::PROT_RST,
                     lock: 1'b0, incr: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign ctl.size = s_q.size;
    assign ctl.prot = s_q.prot;
    assign ctl.lock = s_q.lock;
    assign ctl.incr = s_q.incr;
endmodule
`default_nettype wire

//--- smt_top.sv
`timescale 1ns/1ps
`default_nettype none
module smt_top (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // slave side bank decode
    input wire logic i_memory_slave_select,
    input wire logic [31:0] i_haddr,
    input wire logic i_remap,
    input wire logic i_cs_active_high,
    output logic [7:0] o_bank_chip_select,
    // tester pins
    input wire logic i_test_request_a,
    input wire logic i_test_request_b,
    output logic o_test_acknowledge,
    input wire logic [31:0] i_external_data_bus,
    output logic [31:0] o_external_data_bus,
    output logic o_external_data_bus_oe,
    // test master on the ahb
    output logic o_hbusreq,
    input wire logic i_hgrant,
    input wire logic i_hready,
    input wire logic [1:0] i_hresp,
    input wire logic [31:0] i_hrdata,
    output logic [31:0] o_haddr,
    output logic [1:0] o_htrans,
    output logic o_hwrite,
    output logic [31:0] o_hwdata,
    output logic [2:0] o_test_master_size,
    output logic [3:0] o_test_master_protection,
    output logic o_test_master_lock,
    output logic [2:0] o_hburst
);
    typedef enum logic [2:0] {
        ST_NORMAL = 3'b000,
        ST_REQ = 3'b001,
        ST_IDLE = 3'b010,
        ST_ADDR = 3'b011,
        ST_DATA = 3'b100,
        ST_EXIT = 3'b101
    } smt_state_t;

    typedef struct packed {
        smt_state_t st;
        logic ack;
        logic busreq;
        logic [31:0] addr;
        logic [31:0] pend_vec;
        logic pend;
        logic [1:0] htrans;
        logic hwrite;
        logic [31:0] hwdata;
        logic [31:0] rdata;
        logic oe;
        logic xfer_wr;
        logic exit_req;
        logic multi;
    } smt_state_st_t;

    smt_state_st_t s_q;
    smt_state_st_t s_d;
    logic [1:0] req;
    logic ctl_load;
    logic [9:0] ctl_vec;

    smt_bank_if bank_bus ();
    smt_ctl_if ctl_bus ();

    // bank select path lives apart from the test master
    assign bank_bus.code = i_haddr[smt_pkg::BANK_LSB +: 3];
    assign bank_bus.remap = i_remap;
    assign bank_bus.sel = i_memory_slave_select;
    assign bank_bus.high = i_cs_active_high;
    assign o_bank_chip_select = bank_bus.cs;

    smt_bank_dec u_dec (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .bus(bank_bus.dec)
    );

    assign ctl_bus.load = ctl_load;
    assign ctl_bus.vec = ctl_vec;

    smt_ctl_regs u_ctl (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .ctl(ctl_bus.regs)
    );

    assign req = {i_test_request_a, i_test_request_b};

    // increment only the low eight address bits, wrapping inside them
    function automatic logic [31:0] next_addr(input logic [31:0] a, input logic [2:0] sz);
        logic [7:0] step;
        step = 8'h01 << sz[1:0];
        return {a[31:8], a[7:0] + step};
    endfunction

    // vector sequencer; a run of 11 vectors keeps the last one pending so
    // the one ending a run of two or more is taken as control, the rest as addresses
    always_comb begin
        s_d = s_q;
        ctl_load = 1'b0;
        ctl_vec = s_q.pend_vec[9:0];
        case (s_q.st)
            ST_NORMAL: begin
                s_d.ack = 1'b0;
                s_d.oe = 1'b0;
                if (i_test_request_a) begin
                    s_d.busreq = 1'b1;
                    s_d.st = ST_REQ;
                end
            end
            ST_REQ: begin
                if (i_hgrant && i_hready) begin
                    s_d.ack = 1'b1;
                    s_d.st = ST_IDLE;
                end
            end
            ST_IDLE: begin
                s_d.ack = 1'b1;
                if (req == smt_pkg::REQ_ADDR) begin
                    // the previous pending word was not last, so it is an address
                    if (s_q.pend) begin
                        s_d.addr = s_q.pend_vec;
                    end
                    s_d.multi = s_q.pend;
                    s_d.pend_vec = i_external_data_bus;
                    s_d.pend = 1'b1;
                    s_d.oe = 1'b0;
                end else begin
                    // run ended: a lone one was an address, a longer run ends in control
                    if (s_q.pend && s_q.multi) begin
                        ctl_load = 1'b1;
                    end else if (s_q.pend) begin
                        s_d.addr = s_q.pend_vec;
                    end
                    s_d.pend = 1'b0;
                    s_d.multi = 1'b0;
                    if (req == smt_pkg::REQ_EXIT) begin
                        s_d.st = ST_EXIT;
                    end else begin
                        s_d.xfer_wr = (req == smt_pkg::REQ_WRITE);
                        s_d.hwdata = i_external_data_bus;
                        s_d.oe = 1'b0;
                        s_d.ack = 1'b0;
                        s_d.st = ST_ADDR;
                    end
                end
            end
            ST_ADDR: begin
                s_d.ack = 1'b0;
                if (i_hready && i_hgrant) begin
                    s_d.htrans = smt_pkg::TRANS_NSEQ;
                    s_d.hwrite = s_q.xfer_wr;
                    s_d.st = ST_DATA;
                end
            end
            ST_DATA: begin
                s_d.ack = 1'b0;
                if (s_q.htrans == smt_pkg::TRANS_NSEQ && i_hready) begin
                    s_d.htrans = smt_pkg::TRANS_IDLE;
                end else if (i_hready) begin
                    if (i_hresp[1]) begin
                        // retry or split: reissue the same address phase
                        s_d.st = ST_ADDR;
                    end else begin
                        if (!s_q.hwrite) begin
                            s_d.rdata = i_hrdata;
                            s_d.oe = 1'b1;
                        end
                        if (ctl_bus.incr) begin
                            s_d.addr = next_addr(s_q.addr, ctl_bus.size);
                        end
                        s_d.ack = 1'b1;
                        s_d.st = ST_IDLE;
                    end
                end
            end
            ST_EXIT: begin
                s_d.busreq = 1'b0;
                s_d.ack = 1'b0;
                s_d.oe = 1'b0;
                s_d.htrans = smt_pkg::TRANS_IDLE;
                if (!i_test_request_a) begin
                    s_d.st = ST_NORMAL;
                end
            end
            default: begin
                s_d.st = ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // pins and master outputs come straight from flip-flops
    assign o_test_acknowledge = s_q.ack;
    assign o_hbusreq = s_q.busreq;
    assign o_haddr = s_q.addr;
    assign o_htrans = s_q.htrans;
    assign o_hwrite = s_q.hwrite;
    assign o_hwdata = s_q.hwdata;
    assign o_external_data_bus = s_q.rdata;
    assign o_external_data_bus_oe = s_q.oe;
    assign o_test_master_size = ctl_bus.size;
    assign o_test_master_protection = ctl_bus.prot;
    assign o_test_master_lock = ctl_bus.lock;
    // only incrementing bursts of undefined length are ever issued
    assign o_hburst = 3'h1;
endmodule
`default_nettype wire

//--- smt_sva.sv
`timescale 1ns/1ps
`default_nettype none
module smt_sva (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_memory_slave_select,
    input wire logic [31:0] i_haddr,
    input wire logic i_remap,
    input wire logic i_cs_active_high,
    input wire logic [7:0] o_bank_chip_select,
    input wire logic i_test_request_a,
    input wire logic i_test_request_b,
    input wire logic o_test_acknowledge,
    input wire logic o_hbusreq,
    input wire logic i_hgrant,
    input wire logic [1:0] o_htrans,
    input wire logic [2:0] o_test_master_size,
    input wire logic [3:0] o_test_master_protection
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rstn);
    logic [7:0] dec_exp;
    // expected select; unmapped code zero points at the top bank
    always_comb begin
        dec_exp = 8'h01 << i_haddr[28:26];
        if (!i_remap && i_haddr[28:26] == 3'h0) begin
            dec_exp = 8'h80;
        end
        if (!i_cs_active_high) begin
            dec_exp = ~dec_exp;
        end
    end
    // inputs held across one edge, so a registered decoder has caught up
    sequence s_dec_steady;
        $past(i_rstn) && i_memory_slave_select && $past(i_memory_slave_select)
            && $stable(i_haddr[28:26])
            && $stable(i_remap) && $stable(i_cs_active_high);
    endsequence
    a_bank_decode: assert property (s_dec_steady |-> o_bank_chip_select == dec_exp)
        else $error("bank select mismatch");
    a_size_top_low: assert property (o_test_master_size[2] == 1'b0)
        else $error("size top bit high");
    a_reset_ctl: assert property (!$past(i_rstn) |-> o_test_master_size == smt_pkg::SIZE_RST
        && o_test_master_protection == smt_pkg::PROT_RST) else $error("control not at reset");
    a_req_busreq: assert property ($rose(i_test_request_a) && !o_test_acknowledge |-> ##[0:8] o_hbusreq)
        else $error("no bus request on test entry");
    a_trans_granted: assert property (o_htrans != smt_pkg::TRANS_IDLE |-> $past(i_hgrant))
        else $error("transfer without grant");
    a_ack_exit: assert property (o_test_acknowledge && !i_test_request_a && !i_test_request_b
        |-> ##[1:16] !o_test_acknowledge) else $error("exit not honoured");
    a_idle_quiet: assert property (!i_test_request_a && !o_test_acknowledge && !o_hbusreq
        |=> !o_test_acknowledge) else $error("acknowledge in normal mode");
    a_ack_granted: assert property ($rose(o_test_acknowledge) |-> i_hgrant)
        else $error("acknowledge without bus");
    a_ack_busy: assert property (o_htrans != smt_pkg::TRANS_IDLE |-> !o_test_acknowledge)
        else $error("acknowledge high during transfer");
endmodule
bind smt_top smt_sva smt_sva_inst (.*);
`default_nettype wire

//--- smt_ahb_far.sv
`timescale 1ns/1ps
`default_nettype none
module smt_ahb_far (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_slow,
    input wire logic i_hbusreq,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [31:0] i_hwdata,
    output logic o_hgrant,
    output logic o_hready,
    output logic [31:0] o_hrdata
);
    logic [31:0] mem [16];
    logic [31:0] last;
    logic [3:0] idx;
    logic act, wr, waited;
    // one wait state per data phase when slow
    assign o_hready = !act || !i_slow || waited;
    // outside a read data phase the bus shows junk, not the old value
    assign o_hrdata = (act && !wr) ? mem[idx] : ~last;
    // grant lags request a cycle, as a pipelined arbiter would
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_hgrant <= 1'b0;
            act <= 1'b0;
            waited <= 1'b0;
            last <= 32'h0;
        end else begin
            o_hgrant <= i_hbusreq;
            waited <= act && !o_hready;
            if (o_hready && act && wr) mem[idx] <= i_hwdata;
            if (o_hready && act && !wr) last <= mem[idx];
            if (o_hready) begin
                act <= i_htrans[1];
                wr <= i_hwrite;
                idx <= i_haddr[5:2];
            end
        end
    end
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic i_sys_clk = 1'b0, i_rstn = 1'b0, i_memory_slave_select = 1'b1, slow = 1'b0;
    logic i_remap = 1'b0, i_cs_active_high = 1'b0, i_test_request_a = 1'b0, i_test_request_b = 1'b0;
    logic i_hgrant, i_hready, o_test_acknowledge, o_external_data_bus_oe, o_hbusreq;
    logic o_hwrite, o_test_master_lock;
    logic [1:0] i_hresp = 2'h0, o_htrans;
    logic [2:0] o_test_master_size, o_hburst;
    logic [3:0] o_test_master_protection;
    logic [7:0] o_bank_chip_select;
    logic [31:0] i_haddr = 32'h0, tdata = 32'h0, i_hrdata, o_haddr, o_hwdata, o_external_data_bus;
    // shared pad: the tester lets go whenever the controller drives
    wire logic [31:0] i_external_data_bus = o_external_data_bus_oe ? o_external_data_bus : tdata;
    int n_errors = 0;
    int checks_done = 0;
    // remap, polarity, code, expected select
    logic [12:0] rows [11] = '{13'h1801, 13'h1902, 13'h1A04, 13'h1B08, 13'h1C10, 13'h1D20,
        13'h1E40, 13'h1F80, 13'h0880, 13'h007F, 13'h03F7};
    smt_top smt_top_inst (.*);
    smt_ahb_far smt_ahb_far_inst (.i_sys_clk, .i_rstn, .i_slow(slow), .i_hbusreq(o_hbusreq),
        .i_haddr(o_haddr), .i_htrans(o_htrans), .i_hwrite(o_hwrite), .i_hwdata(o_hwdata),
        .o_hgrant(i_hgrant), .o_hready(i_hready), .o_hrdata(i_hrdata));
    // clock
    always #5 i_sys_clk = ~i_sys_clk;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // bounded wait, sampled mid-cycle so the value is settled
    task automatic wt(input logic v);
        int n;
        n = 0;
        @(negedge i_sys_clk);
        while (o_test_acknowledge !== v && n < 100) begin
            @(negedge i_sys_clk);
            n++;
        end
        if (n == 100) chk("ack wait", 32'(v), 32'(o_test_acknowledge));
    endtask
    // put the next vector on the pins; it is held until taken
    task automatic nxt(input logic [1:0] ab, input logic [31:0] d);
        {i_test_request_a, i_test_request_b} <= ab;
        tdata <= d;
    endtask
    // vector is taken at the first edge with acknowledge high
    task automatic vec(input logic [1:0] ab, input logic [31:0] d);
        nxt(ab, d);
        wt(1'b1);
        @(posedge i_sys_clk);
    endtask
    // the first turnaround waits on the pins while the read runs, so the
    // read vector is never taken twice
    task automatic rd(input logic [31:0] e);
        vec(smt_pkg::REQ_READ, 32'h0);
        nxt(smt_pkg::REQ_ADDR, 32'h40);
        wt(1'b0);
        wt(1'b1);
        chk("read drive", 32'h1, 32'(o_external_data_bus_oe));
        chk("read data", e, o_external_data_bus);
        @(posedge i_sys_clk);
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        n_errors++;
        finish_test();
    end
    // main sequence
    initial begin
        repeat (3) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        @(negedge i_sys_clk);
        chk("reset size", 32'(smt_pkg::SIZE_RST), 32'(o_test_master_size));
        chk("reset prot", 32'(smt_pkg::PROT_RST), 32'(o_test_master_protection));
        chk("reset ack", 32'h0, 32'(o_test_acknowledge));
        @(posedge i_sys_clk);
        foreach (rows[k]) begin
            {i_remap, i_cs_active_high} <= rows[k][12:11];
            i_haddr <= {3'h0, rows[k][10:8], 26'h0};
            repeat (2) @(posedge i_sys_clk);
            @(negedge i_sys_clk);
            chk("bank select", 32'(rows[k][7:0]), 32'(o_bank_chip_select));
            @(posedge i_sys_clk);
        end
        vec(smt_pkg::REQ_ADDR, 32'h40);
        vec(smt_pkg::REQ_ADDR, 32'h40);
        vec(smt_pkg::REQ_WRITE, 32'hA5A50001);
        rd(32'hA5A50001);
        vec(smt_pkg::REQ_ADDR, 32'h40);
        vec(smt_pkg::REQ_ADDR, 32'h40);
        slow <= 1'b1;
        vec(smt_pkg::REQ_ADDR, 32'h88);
        vec(smt_pkg::REQ_ADDR, 32'h3FE);
        vec(smt_pkg::REQ_WRITE, 32'h0BAD0001);
        vec(smt_pkg::REQ_WRITE, 32'h0BAD0002);
        nxt(smt_pkg::REQ_ADDR, 32'h88);
        wt(1'b1);
        chk("ignored size", 32'(smt_pkg::SIZE_RST), 32'(o_test_master_size));
        chk("fixed addr", 32'h0BAD0002, smt_ahb_far_inst.mem[2]);
        @(posedge i_sys_clk);
        vec(smt_pkg::REQ_ADDR, 32'hB9);
        vec(smt_pkg::REQ_WRITE, 32'hC0DE0003);
        vec(smt_pkg::REQ_WRITE, 32'hC0DE0004);
        nxt(smt_pkg::REQ_EXIT, 32'h0);
        wt(1'b1);
        chk("ctl prot", {28'h0, smt_pkg::PROT_RST[3], 3'h1}, 32'(o_test_master_protection));
        chk("ctl lock", 32'h1, 32'(o_test_master_lock));
        chk("incr addr", 32'hC0DE0004, smt_ahb_far_inst.mem[3]);
        chk("incr base", 32'hC0DE0003, smt_ahb_far_inst.mem[2]);
        @(posedge i_sys_clk);
        wt(1'b0);
        repeat (4) @(posedge i_sys_clk);
        chk("exit busreq", 32'h0, 32'(o_hbusreq));
        finish_test();
    end
endmodule
`default_nettype wire
